//--- hw/dce_top.sv
// Our own choices: the strobed register port and the address map.
`timescale 1ns/10ps
// Function
// RULE_01: Result high only when positive exceeds negative.
// RULE_02: Positive two pins; negative pin or reference.
// RULE_03: Result readable and optionally drives pin.
// RULE_04: Output change sets per-comparator change flag.
// RULE_05: Software waits settling, clears flag first.
// RULE_06: Disabled comparator result forced high.
// RULE_07: Forced low-to-high sets flag, maybe interrupt.
// RULE_08: Software disables interrupt before comparator.
// RULE_09: One shared interrupt; software reads both flags.
// RULE_10: Run in idle/power-down; off in total.
// RULE_11: Enabled change interrupts and wakes processor.
// RULE_12: Power control bit 5 disables both comparators.
// RULE_13: Software uses push-pull for routed pin.
// RULE_14: Request while flag and enable both set.
// RULE_15: Flag sticky until written zero; edge detected.
module dce_top
  import dce_pkg::*;
#(
  parameter int NUM_CMP = 2  // Number of comparator lanes.
)
(
  // Clock and reset.
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  // Register port.
  input  wire logic [3:0]       addr_in,
  input  wire logic [7:0]       wdata_in,
  input  wire logic             wr_in,
  input  wire logic             rd_in,
  output logic      [7:0]       rdata_out,
  // Analog cores: per lane, {nsel, psel} indexed comparisons.
  input  wire logic [4*NUM_CMP-1:0] core_gt_in,
  // Analog side controls and pins.
  output logic      [NUM_CMP-1:0] core_en_out,
  output logic      [NUM_CMP-1:0] psel_out,
  output logic      [NUM_CMP-1:0] nsel_out,
  output logic      [NUM_CMP-1:0] pin_o_out,
  output logic      [NUM_CMP-1:0] pin_oe_out,
  // Interrupt and wake.
  output logic                  irq_out,
  output logic                  wake_out
);

  logic [7:0]         cfg_q [NUM_CMP];  // Configuration registers.
  logic [7:0]         ppc_q;            // Peripheral power control.
  logic [1:0]         mode_q;           // Power mode.
  logic [NUM_CMP-1:0] flag_q;           // Sticky change flags.
  logic [NUM_CMP-1:0] status_q;         // Sticky status for interrupt unit.
  logic [NUM_CMP-1:0] irq_en_q;         // Interrupt unit enables.
  logic [7:0]         rdata_q;          // Read data register.
  logic               irq_q;            // Registered interrupt.
  logic               wake_q;           // Registered wake.
  logic [NUM_CMP-1:0] en_q;             // Registered effective enable.
  logic [NUM_CMP-1:0] res;              // Lane results.
  logic [NUM_CMP-1:0] chg;              // Lane change pulses.
  logic [NUM_CMP-1:0] eff_en;           // Effective enables.
  logic [NUM_CMP-1:0] ie;               // Per-lane interrupt enables.
  logic [NUM_CMP-1:0] clr_wr;           // Write-one clear strobe.

  // Decode of write targets.
  wire logic wr_ppc  = wr_in && (addr_in == DCE_PPC_OFS);
  wire logic wr_clr  = wr_in && (addr_in == DCE_CLR_OFS);
  wire logic wr_en   = wr_in && (addr_in == DCE_EN_OFS);
  wire logic wr_mode = wr_in && (addr_in == DCE_MODE_OFS);
  // Total power-down or the power bit shuts both cores.
  wire logic cmp_off = ppc_q[DCE_PPC_CMP_BIT] || (mode_q == DCE_MODE_TOTAL); // RULE_10 RULE_12
  wire logic req     = |(flag_q & ie); // RULE_14 RULE_09

  assign clr_wr = wr_clr ? wdata_in[NUM_CMP-1:0] : '0;

  // One lane per comparator, each with its own configuration register.
  for (genvar g = 0; g < NUM_CMP; g++) begin : g_lane
    wire logic wr_cfg = wr_in && (addr_in == (DCE_CFG0_OFS + 4'(g)));
    assign eff_en[g] = cfg_q[g][DCE_CFG_EN_BIT] && !cmp_off;
    assign ie[g]     = cfg_q[g][DCE_CFG_IE_BIT];

    dce_cmp_lane u_lane (
      .clk_in     (clk_in),
      .rst_n_in   (rst_n_in),
      .core_gt_in (core_gt_in[4*g +: 4]),
      .enable_in  (eff_en[g]),
      .psel_in    (cfg_q[g][DCE_CFG_PSEL_BIT]),
      .nsel_in    (cfg_q[g][DCE_CFG_NSEL_BIT]),
      .result_out (res[g]),
      .change_out (chg[g])
    );

    // Configuration and flag; a change in the same cycle as a clear wins.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
        cfg_q[g]  <= DCE_CFG_RST;
        flag_q[g] <= 1'b0;
      end else begin
        if (wr_cfg) begin
          cfg_q[g] <= wdata_in;
        end
        if (chg[g]) begin
          flag_q[g] <= 1'b1; // RULE_04 RULE_07
        end else if (wr_cfg && !wdata_in[DCE_CFG_FLAG_BIT]) begin
          flag_q[g] <= 1'b0; // RULE_15
        end
      end
    end

    // Status for the interrupt unit, cleared by writing one.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
        status_q[g] <= 1'b0;
      end else if (chg[g]) begin
        status_q[g] <= 1'b1;
      end else if (clr_wr[g]) begin
        status_q[g] <= 1'b0;
      end
    end
  end

  // Read mux; the result bit reflects the live comparator.
  function automatic logic [7:0] cfg_view(input int i);
    logic [7:0] v;
    v = cfg_q[i];
    v[DCE_CFG_RES_BIT]  = res[i]; // RULE_03
    v[DCE_CFG_FLAG_BIT] = flag_q[i];
    v[7]                = 1'b0;
    return v;
  endfunction

  logic [7:0] rd_mux;  // Selected read value.
  always_comb begin
    rd_mux = 8'h00;
    unique case (addr_in)
      DCE_CFG0_OFS: rd_mux = cfg_view(0);
      DCE_CFG1_OFS: rd_mux = cfg_view(1);
      DCE_PPC_OFS:  rd_mux = ppc_q;
      DCE_STAT_OFS: rd_mux = 8'(status_q);
      DCE_EN_OFS:   rd_mux = 8'(irq_en_q);
      DCE_MODE_OFS: rd_mux = 8'(mode_q);
      default:      rd_mux = 8'h00;
    endcase
  end

  // Control registers and registered outputs.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ppc_q    <= DCE_PPC_RST;
      mode_q   <= DCE_MODE_RST;
      irq_en_q <= '0;
      rdata_q  <= 8'h00;
      irq_q    <= 1'b0;
      wake_q   <= 1'b0;
      en_q     <= '0;
    end else begin
      if (wr_ppc)  ppc_q    <= wdata_in;
      if (wr_mode) mode_q   <= wdata_in[1:0];
      if (wr_en)   irq_en_q <= wdata_in[NUM_CMP-1:0];
      rdata_q <= rd_in ? rd_mux : 8'h00;
      irq_q   <= req || |(status_q & irq_en_q); // RULE_11
      wake_q  <= req && (mode_q != DCE_MODE_TOTAL) && (mode_q != DCE_MODE_RUN); // RULE_11
      en_q    <= eff_en;
    end
  end

  // Pin routing and core controls, all from flip-flops.
  logic [NUM_CMP-1:0] psel_q;  // Positive select.
  logic [NUM_CMP-1:0] nsel_q;  // Negative select.
  logic [NUM_CMP-1:0] pin_q;   // Pin level.
  logic [NUM_CMP-1:0] oe_q;    // Pin enable.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      psel_q <= '0;
      nsel_q <= '0;
      pin_q  <= '1;
      oe_q   <= '0;
    end else begin
      for (int i = 0; i < NUM_CMP; i++) begin
        psel_q[i] <= cfg_q[i][DCE_CFG_PSEL_BIT];
        nsel_q[i] <= cfg_q[i][DCE_CFG_NSEL_BIT];
        oe_q[i]   <= cfg_q[i][DCE_CFG_OE_BIT]; // RULE_03
      end
      pin_q <= res;
    end
  end

  assign rdata_out   = rdata_q;
  assign core_en_out = en_q;
  assign psel_out    = psel_q;
  assign nsel_out    = nsel_q;
  assign pin_o_out   = pin_q;
  assign pin_oe_out  = oe_q;
  assign irq_out     = irq_q;
  assign wake_out    = wake_q;

  // Checks.
  // These properties sit beside the logic that they guard and watch design state together with the register-port inputs.
  // Lane 0 carries more of them than lane 1 because every scenario but t_disable exercises it.
  // Lane 1 gets its own copies where the shared interrupt path depends on it.
  // Each property is held off during reset, so it never judges the reset values.
  // A change seen on a lane must leave its flag set on the next edge.
  property p_flag_set;
    @(posedge clk_in) disable iff (!rst_n_in) chg[0] |=> flag_q[0];
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not set"); // RULE_04

  // The forced level passes two register stages, lane state then result, before it shows in the result register.
  property p_off_high;
    @(posedge clk_in) disable iff (!rst_n_in) !eff_en[0] [*2] |=> res[0];
  endproperty
  a_off_high: assert property (p_off_high) else $error("disabled not high"); // RULE_06

  // The registered request follows the combined flag and enable term by one cycle.
  property p_irq;
    @(posedge clk_in) disable iff (!rst_n_in) req |=> irq_out;
  endproperty
  a_irq: assert property (p_irq) else $error("irq missing"); // RULE_14

  // The power bit must drop the core enable, which is what saves the analog current.
  property p_ppc;
    @(posedge clk_in) disable iff (!rst_n_in) ppc_q[DCE_PPC_CMP_BIT] |=> !core_en_out[0];
  endproperty
  a_ppc: assert property (p_ppc) else $error("power bit ignored"); // RULE_12

  property p_total;
    @(posedge clk_in) disable iff (!rst_n_in) (mode_q == DCE_MODE_TOTAL) |=> !core_en_out[1] && !wake_out;
  endproperty
  a_total: assert property (p_total) else $error("total power-down"); // RULE_10

  property p_sticky;
    @(posedge clk_in) disable iff (!rst_n_in) flag_q[1] && !(wr_in && addr_in == DCE_CFG1_OFS) |=> flag_q[1];
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag lost"); // RULE_15

  property p_fall_flag;
    @(posedge clk_in) disable iff (!rst_n_in) (!res[0] && !eff_en[0]) |=> ##[0:2] flag_q[0];
  endproperty
  a_fall_flag: assert property (p_fall_flag) else $error("forced edge unflagged"); // RULE_07

  property p_oe;
    @(posedge clk_in) disable iff (!rst_n_in) cfg_q[0][DCE_CFG_OE_BIT] |=> pin_oe_out[0];
  endproperty
  a_oe: assert property (p_oe) else $error("pin route"); // RULE_03

  // Lane 1 shares the interrupt vector, so its flag path is checked as well.
  property p_flag1_set;
    @(posedge clk_in) disable iff (!rst_n_in) chg[1] |=> flag_q[1];
  endproperty
  a_flag1_set: assert property (p_flag1_set) else $error("lane 1 flag not set"); // RULE_04

  // The status copy for the interrupt unit must follow every change too.
  property p_status1_set;
    @(posedge clk_in) disable iff (!rst_n_in) chg[1] |=> status_q[1];
  endproperty
  a_status1_set: assert property (p_status1_set) else $error("lane 1 status not set"); // RULE_04

  // A disabled lane 1 must read high, the same as lane 0.
  property p_off_high1;
    @(posedge clk_in) disable iff (!rst_n_in) !eff_en[1] [*2] |=> res[1];
  endproperty
  a_off_high1: assert property (p_off_high1) else $error("lane 1 disabled not high"); // RULE_06

  // Writing zero to the flag bit clears it when no change arrives in the same cycle.
  // A change in that cycle would win, so the antecedent excludes it.
  property p_clear0;
    @(posedge clk_in) disable iff (!rst_n_in)
      wr_in && (addr_in == DCE_CFG0_OFS) && !wdata_in[DCE_CFG_FLAG_BIT] && !chg[0] |=> !flag_q[0];
  endproperty
  a_clear0: assert property (p_clear0) else $error("flag clear ignored"); // RULE_15

  // In idle an enabled change must request a wake on the next edge.
  property p_wake;
    @(posedge clk_in) disable iff (!rst_n_in) req && (mode_q == DCE_MODE_IDLE) |=> wake_out;
  endproperty
  a_wake: assert property (p_wake) else $error("wake missing"); // RULE_11

  // In normal run there is nothing to wake, so the wake request stays low.
  property p_no_wake_run;
    @(posedge clk_in) disable iff (!rst_n_in) (mode_q == DCE_MODE_RUN) |=> !wake_out;
  endproperty
  a_no_wake_run: assert property (p_no_wake_run) else $error("wake in run mode"); // RULE_11

  // With no flagged and enabled cause the level interrupt must fall.
  property p_irq_quiet;
    @(posedge clk_in) disable iff (!rst_n_in) !req && !(|(status_q & irq_en_q)) |=> !irq_out;
  endproperty
  a_irq_quiet: assert property (p_irq_quiet) else $error("irq without cause"); // RULE_14

  // The pin shows the result one register later, so a routed pin never glitches.
  property p_pin_level;
    @(posedge clk_in) disable iff (!rst_n_in) 1'b1 |=> (pin_o_out[0] == $past(res[0]));
  endproperty
  a_pin_level: assert property (p_pin_level) else $error("pin level wrong"); // RULE_03

  // Read data are zero outside the cycle after a read strobe.
  property p_rdata_idle;
    @(posedge clk_in) disable iff (!rst_n_in) !rd_in |=> (rdata_out == 8'h00);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle"); // RULE_03

  // A low lane that is switched off must raise its flag through the forced edge.
  // Software that skipped the recommended order sees exactly this interrupt.
  sequence s_low_then_off1;
    (!res[1] && eff_en[1]) ##1 !eff_en[1];
  endsequence
  property p_forced1;
    @(posedge clk_in) disable iff (!rst_n_in) s_low_then_off1 |=> ##1 flag_q[1];
  endproperty
  a_forced1: assert property (p_forced1) else $error("lane 1 forced edge unflagged"); // RULE_07

endmodule

//--- hw/dce_pkg.sv
package dce_pkg;

  // Register offsets on the plain register port, one byte address each.
  localparam logic [3:0] DCE_CFG0_OFS  = 4'h0;
  localparam logic [3:0] DCE_CFG1_OFS  = 4'h1;
  localparam logic [3:0] DCE_PPC_OFS   = 4'h2;
  localparam logic [3:0] DCE_STAT_OFS  = 4'h3;
  localparam logic [3:0] DCE_CLR_OFS   = 4'h4;
  localparam logic [3:0] DCE_EN_OFS    = 4'h5;
  localparam logic [3:0] DCE_MODE_OFS  = 4'h6;

  // Field positions inside each comparator configuration register.
  localparam int DCE_CFG_EN_BIT   = 0;
  localparam int DCE_CFG_PSEL_BIT = 1;
  localparam int DCE_CFG_NSEL_BIT = 2;
  localparam int DCE_CFG_OE_BIT   = 3;
  localparam int DCE_CFG_IE_BIT   = 4;
  localparam int DCE_CFG_RES_BIT  = 5;
  localparam int DCE_CFG_FLAG_BIT = 6;

  // Comparator power-off bit in the peripheral power control register.
  localparam int DCE_PPC_CMP_BIT = 5;

  // Power mode encoding written to the mode register.
  localparam logic [1:0] DCE_MODE_RUN   = 2'h0;
  localparam logic [1:0] DCE_MODE_IDLE  = 2'h1;
  localparam logic [1:0] DCE_MODE_PD    = 2'h2;
  localparam logic [1:0] DCE_MODE_TOTAL = 2'h3;

  // Values after reset.
  localparam logic [7:0] DCE_CFG_RST  = 8'h00;
  localparam logic [7:0] DCE_PPC_RST  = 8'h00;
  localparam logic [1:0] DCE_MODE_RST = 2'h0;

  // Settling time after enable, kept here for software drivers.
  localparam int DCE_SETTLE_US  = 10;
  localparam int DCE_CLK_MHZ    = 10;
  localparam int DCE_SETTLE_CYC = DCE_SETTLE_US * DCE_CLK_MHZ;

  // Per-comparator pipeline states.
  typedef enum logic [1:0] {
    DCE_ST_OFF  = 2'b00,
    DCE_ST_LIVE = 2'b01
  } dce_state_e;

endpackage

//--- hw/dce_cmp_lane.sv
`timescale 1ns/10ps
// One comparator lane: input selection, result forcing and change detection.
module dce_cmp_lane
  import dce_pkg::*;
(
  // Clock and reset.
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  // Analog core result per input combination: index {nsel, psel}.
  input  wire logic [3:0] core_gt_in,
  // Control.
  input  wire logic enable_in,
  input  wire logic psel_in,
  input  wire logic nsel_in,
  // Outputs.
  output logic      result_out,
  output logic      change_out
);

  logic       sync1_q;  // First synchroniser stage.
  logic       sync2_q;  // Second synchroniser stage.
  logic       res_q;    // Registered result.
  logic       res_d;    // Next result.
  dce_state_e st_q;     // Lane state.
  wire  logic pick = core_gt_in[{nsel_in, psel_in}];

  // A disabled comparator reads high, so turning off from low is a change.
  assign res_d = (st_q == DCE_ST_LIVE) ? sync2_q : 1'b1; // RULE_06

  // Synchronise the selected core output and track the result.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
      res_q   <= 1'b1;
      st_q    <= DCE_ST_OFF;
    end else begin
      sync1_q <= pick; // RULE_02
      sync2_q <= sync1_q; // RULE_01
      res_q   <= res_d;
      st_q    <= enable_in ? DCE_ST_LIVE : DCE_ST_OFF;
    end
  end

  assign result_out = res_q;
  // Any edge of the result, including the forced one, is a change.
  assign change_out = res_d ^ res_q; // RULE_15 RULE_07

endmodule

//--- tb/dce_analog_model.sv
`timescale 1ns/10ps
// Behavioural stand-in for the two analog comparator cores.
module dce_analog_model #(
  parameter logic [7:0] REF_LVL = 8'h80  // Internal reference level, arbitrary scale.
)
(
  input  wire logic        clk_in,  // Used only to scramble a disabled core.
  input  wire logic [1:0]  en_in,   // Core enables.
  input  wire logic [47:0] lvl_in,  // Per lane: neg pin, pos B, pos A.
  output logic      [7:0]  gt_out   // Per lane, index {nsel, psel}.
);
  logic junk_q = 1'b0;  // Toggles so a stale answer never looks stable.

  // A powered-down core gives no valid answer, so show a changing pattern.
  always @(posedge clk_in) begin
    junk_q <= ~junk_q;
  end

  for (genvar g = 0; g < 2; g++) begin : g_lane
    for (genvar k = 0; k < 4; k++) begin : g_idx
      wire logic [7:0] pos = lvl_in[24*g+8*(k%2) +: 8];
      wire logic [7:0] neg = (k > 1) ? REF_LVL : lvl_in[24*g+16 +: 8];
      // Strictly greater only; equal levels give zero.
      assign gt_out[4*g+k] = en_in[g] ? (pos > neg) : junk_q;
    end
  end
endmodule

//--- tb/test_dce_top.sv
`timescale 1ns/10ps
// Self-checking bench for the comparator event block.
module test_dce_top
  import dce_pkg::*;
;
  logic        clk_in   = 1'b0;
  logic        rst_n_in = 1'b0;
  logic [3:0]  addr_in  = 4'h0;
  logic [7:0]  wdata_in = 8'h00;
  logic        wr_in    = 1'b0;
  logic        rd_in    = 1'b0;
  logic [47:0] lvl      = 48'h0;  // Analog levels seen by the model.
  logic [7:0]  rdata_out, core_gt_in;
  logic [1:0]  core_en_out, psel_out, nsel_out, pin_o_out, pin_oe_out;
  logic        irq_out, wake_out;
  int          n_errors, check_count;

  dce_top i_dut (.clk_in, .rst_n_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .core_gt_in,
    .core_en_out, .psel_out, .nsel_out, .pin_o_out, .pin_oe_out, .irq_out, .wake_out);
  dce_analog_model i_core (.clk_in, .en_in(core_en_out), .lvl_in(lvl), .gt_out(core_gt_in));

  // Clock at 10 MHz.
  initial begin
    forever #50 clk_in = ~clk_in;
  end

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // Bus tasks start on a rising edge; a gap cycle avoids double strobe updates.
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so sample mid-cycle.
  task automatic rdc(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    @(negedge clk_in);
    chk(rdata_out, e);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk_in);
    @(negedge clk_in);
  endtask

  // Bounded wait on the interrupt (0) or the wake request (1).
  task automatic wait_for(input bit w, input logic v);
    for (int i = 0; i < 12; i++) begin
      @(negedge clk_in);
      if ((w ? wake_out : irq_out) === v) break;
    end
    chk({7'h0, w ? wake_out : irq_out}, {7'h0, v});
  endtask

  task automatic t_regs;
    rdc(DCE_CFG0_OFS, 8'h20);
    rdc(4'hf, 8'h00);
    $display("t_regs done");
  endtask

  // Walk every input selection on lane 0 with the pin routed.
  task automatic t_select;
    lvl[23:0] <= 24'ha08090;
    for (int k = 0; k < 4; k++) begin
      wr(DCE_CFG0_OFS, 8'h09 | 8'(k << 1));
      settle(10);
      wr(DCE_CFG0_OFS, 8'h09 | 8'(k << 1));
      settle(2);
      chk({7'h0, pin_o_out[0]}, {7'h0, k == 2});
      chk({6'h0, nsel_out[0], psel_out[0]}, 8'(k));
      chk({7'h0, pin_oe_out[0]}, 8'h01);
      rdc(DCE_CFG0_OFS, 8'h09 | 8'(k << 1) | (k == 2 ? 8'h20 : 8'h00));
    end
    $display("t_select done");
  endtask

  // Lane 1 change raises the shared request; flags tell which lane.
  task automatic t_irq;
    lvl[47:24] <= 24'h201010;
    wr(DCE_CFG0_OFS, 8'h0f);
    wr(DCE_CFG1_OFS, 8'h01);
    settle(10);
    wr(DCE_CLR_OFS, 8'h03);
    wr(DCE_CFG1_OFS, 8'h11);
    rdc(DCE_STAT_OFS, 8'h00);
    lvl[31:24] <= 8'h30;
    wait_for(0, 1'b1);
    rdc(DCE_CFG1_OFS, 8'h71);
    rdc(DCE_CFG0_OFS, 8'h0f);
    rdc(DCE_STAT_OFS, 8'h02);
    wr(DCE_CFG1_OFS, 8'h51);
    rdc(DCE_CFG1_OFS, 8'h71);
    wr(DCE_CFG1_OFS, 8'h11);
    wait_for(0, 1'b0);
    wr(DCE_EN_OFS, 8'h02);
    wait_for(0, 1'b1);
    wr(DCE_CLR_OFS, 8'h02);
    wait_for(0, 1'b0);
    $display("t_irq done");
  endtask

  // Disabling a low lane forces it high, which counts as a change.
  task automatic t_disable;
    wr(DCE_EN_OFS, 8'h00);
    lvl[31:24] <= 8'h10;
    settle(10);
    wr(DCE_CLR_OFS, 8'h02);
    wr(DCE_CFG1_OFS, 8'h11);
    wait_for(0, 1'b0);
    wr(DCE_CFG1_OFS, 8'h10);
    wait_for(0, 1'b1);
    chk({7'h0, core_en_out[1]}, 8'h00);
    rdc(DCE_CFG1_OFS, 8'h70);
    wr(DCE_CFG1_OFS, 8'h00);
    $display("t_disable done");
  endtask

  // Idle and power-down keep the lane alive; total mode and the power bit stop it.
  task automatic t_power;
    wr(DCE_CFG0_OFS, 8'h1f);
    for (int m = 1; m < 3; m++) begin
      wr(DCE_MODE_OFS, 8'(m));
      lvl[15:8] <= (m == 1) ? 8'h90 : 8'h70;
      wait_for(1, 1'b1);
      chk({6'h0, core_en_out}, 8'h01);
      wr(DCE_CFG0_OFS, 8'h1f);
      wait_for(1, 1'b0);
    end
    wr(DCE_CFG0_OFS, 8'h0f);
    wr(DCE_MODE_OFS, {6'h0, DCE_MODE_TOTAL});
    settle(6);
    chk({6'h0, core_en_out}, 8'h00);
    chk({7'h0, pin_o_out[0]}, 8'h01);
    wr(DCE_MODE_OFS, {6'h0, DCE_MODE_RUN});
    wr(DCE_PPC_OFS, 8'h20);
    settle(4);
    chk({6'h0, core_en_out}, 8'h00);
    rdc(DCE_PPC_OFS, 8'h20);
    $display("t_power done");
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Watchdog: the tests need well under a thousand cycles.
  initial begin
    repeat (5000) @(posedge clk_in);
    n_errors++;
    end_sim();
  end

  initial begin
    repeat (20) @(posedge clk_in);
    chk({6'h0, pin_o_out}, 8'h03);
    rst_n_in <= 1'b1;
    t_regs();
    t_select();
    t_irq();
    t_disable();
    t_power();
    end_sim();
  end
endmodule
